// >>> rtl/compare_unit_pkg.sv
// Constants, register map and carrier types for the dual compare unit.
// Assumes a 32-bit classic Wishbone master and timers kept outside.
package compare_unit_pkg;

  // Widths
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned TIMER_W  = 16;
  localparam int unsigned ADDR_W   = 6;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned MODE_W   = 4;
  localparam int unsigned LSB_W    = 2;
  localparam int unsigned UNITS    = 2;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_U1_LOW   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_U1_HIGH  = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_U1_CTRL  = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_U2_LOW   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_U2_HIGH  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_U2_CTRL  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ENABLE   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_TBASE    = 6'h20;

  // Control register fields
  localparam int unsigned    CTRL_MODE_LSB = 0;
  localparam int unsigned    CTRL_DUTY_LSB = 4;
  localparam logic [7:0]     CTRL_RESET    = 8'h00;
  localparam logic [7:0]     CTRL_MASK     = 8'h3F;
  localparam logic [7:0]     VALUE_RESET   = 8'h00;

  // Mode select encodings
  localparam logic [MODE_W-1:0] MODE_OFF      = 4'h0;
  localparam logic [MODE_W-1:0] MODE_TOGGLE   = 4'h2;
  localparam logic [MODE_W-1:0] MODE_SET_HIGH = 4'h8;
  localparam logic [MODE_W-1:0] MODE_SET_LOW  = 4'h9;
  localparam logic [MODE_W-1:0] MODE_SOFT_IRQ = 4'hA;
  localparam logic [MODE_W-1:0] MODE_TRIGGER  = 4'hB;
  localparam logic [1:0]        MODE_PWM_TOP  = 2'h3;

  // Timer side inputs gathered from the timers outside
  typedef struct packed {
    logic [TIMER_W-1:0] first_count;
    logic [TIMER_W-1:0] third_count;
    logic [BYTE_W-1:0]  second_count;
    logic [LSB_W-1:0]   second_fine;
    logic               second_period_match;
    logic               first_write;
    logic               third_write;
  } timer_in_s;

  // Special event trigger outputs
  typedef struct packed {
    logic first_clear;
    logic third_clear;
    logic conv_start;
  } trigger_s;

endpackage

// >>> rtl/dual_compare_match_unit.sv
// Two compare / pulse-width units with a classic Wishbone register slave.
// Assumes timer counts arrive synchronous to clk_i from timers outside.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
module dual_compare_match_unit
  import compare_unit_pkg::*;
#(
  parameter int unsigned VALUE_W = 16,
  parameter int unsigned DUTY_W  = 10
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [compare_unit_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [compare_unit_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic [compare_unit_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [compare_unit_pkg::DATA_W-1:0] wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire compare_unit_pkg::timer_in_s       timers_i,
  input  wire logic                              adc_enable_i,
  input  wire logic [compare_unit_pkg::UNITS-1:0]  port_c_direction_i,
  output logic      [compare_unit_pkg::UNITS-1:0]  unit_pin_o,
  output logic      [compare_unit_pkg::UNITS-1:0]  unit_pin_oe_o,
  output logic      [compare_unit_pkg::UNITS-1:0]  match_request_o,
  output compare_unit_pkg::trigger_s             triggers_o
);
  import compare_unit_pkg::*;

  // Logic is written for the documented two-byte value and 10-bit duty
  if (VALUE_W != TIMER_W || VALUE_W != 2 * BYTE_W) begin : g_bad_value
    $error("VALUE_W must be 16");
  end
  if (DUTY_W != BYTE_W + LSB_W) begin : g_bad_duty
    $error("DUTY_W must be 10");
  end

  function automatic logic is_compare(input logic [MODE_W-1:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET_HIGH) ||
           (m == MODE_SET_LOW) || (m == MODE_SOFT_IRQ) ||
           (m == MODE_TRIGGER);
  endfunction

  function automatic logic is_pwm(input logic [MODE_W-1:0] m);
    return m[MODE_W-1:MODE_W-2] == MODE_PWM_TOP;
  endfunction

  function automatic logic [ADDR_W-1:0] unit_ofs(input int unsigned u,
                                                 input int unsigned k);
    logic [ADDR_W-1:0] r;
    r = OFS_U1_LOW;
    unique case ({u[0], k[1:0]})
      3'b000:  r = OFS_U1_LOW;
      3'b001:  r = OFS_U1_HIGH;
      3'b010:  r = OFS_U1_CTRL;
      3'b100:  r = OFS_U2_LOW;
      3'b101:  r = OFS_U2_HIGH;
      default: r = OFS_U2_CTRL;
    endcase
    return r;
  endfunction

  logic [UNITS-1:0][BYTE_W-1:0] low_q;
  logic [UNITS-1:0][BYTE_W-1:0] high_q;
  logic [UNITS-1:0][BYTE_W-1:0] ctrl_q;
  logic [UNITS-1:0][LSB_W-1:0]  lat_q;
  logic [UNITS-1:0]             pin_q;
  logic [UNITS-1:0]             flag_q;
  logic [UNITS-1:0]             enable_q;
  logic [UNITS-1:0]             tbase_q;
  logic [UNITS-1:0]             eq_q;
  logic [UNITS-1:0]             eq_d;
  logic [UNITS-1:0]             hit;
  logic [UNITS-1:0]             fire;
  logic [UNITS-1:0]             wr_low;
  logic [UNITS-1:0]             wr_high;
  logic [UNITS-1:0]             wr_ctrl;
  logic                         ack_q;
  logic [DATA_W-1:0]            rdata_q;
  logic [DATA_W-1:0]            rdata_d;
  logic                         wr_en;
  logic                         first_clr_q;
  logic                         third_clr_q;
  logic                         conv_q;
  logic [BYTE_W-1:0]            wbyte;

  // Writes land on the edge where the master samples ack
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign wbyte = wb_dat_i[BYTE_W-1:0];

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      wr_low[u]  = wr_en && (wb_adr_i == unit_ofs(u, 0));
      wr_high[u] = wr_en && (wb_adr_i == unit_ofs(u, 1));
      wr_ctrl[u] = wr_en && (wb_adr_i == unit_ofs(u, 2));
    end
  end

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      eq_d[u] = {high_q[u], low_q[u]} == (tbase_q[u] ?
                timers_i.third_count : timers_i.first_count);
      // Act once on reaching equality, so a stalled timer fires once
      hit[u]  = is_compare(ctrl_q[u][MODE_W-1:0]) && eq_d[u] && !eq_q[u];
      fire[u] = hit[u] && (ctrl_q[u][MODE_W-1:0] == MODE_TRIGGER);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_q <= '0;
    end else if (ce_i) begin
      eq_q <= eq_d;
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (ce_i) begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (wb_adr_i)
      OFS_U1_LOW:  rdata_d[BYTE_W-1:0] = low_q[0];
      OFS_U1_HIGH: rdata_d[BYTE_W-1:0] = high_q[0];
      OFS_U1_CTRL: rdata_d[BYTE_W-1:0] = ctrl_q[0];
      OFS_U2_LOW:  rdata_d[BYTE_W-1:0] = low_q[1];
      OFS_U2_HIGH: rdata_d[BYTE_W-1:0] = high_q[1];
      OFS_U2_CTRL: rdata_d[BYTE_W-1:0] = ctrl_q[1];
      OFS_FLAGS:   rdata_d[UNITS-1:0]  = flag_q;
      OFS_ENABLE:  rdata_d[UNITS-1:0]  = enable_q;
      OFS_TBASE:   rdata_d[UNITS-1:0]  = tbase_q;
      default:     rdata_d = '0;
    endcase
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      low_q  <= '0;
    end else if (ce_i) begin
      for (int u = 0; u < UNITS; u++) begin
        if (wr_ctrl[u]) begin
          ctrl_q[u] <= wbyte & CTRL_MASK;
        end
        if (wr_low[u]) begin
          low_q[u] <= wbyte;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_q <= '0;
      lat_q  <= '0;
    end else if (ce_i) begin
      for (int u = 0; u < UNITS; u++) begin
        if (is_pwm(ctrl_q[u][MODE_W-1:0])) begin
          // High byte is read-only while pulse-width runs
          if (timers_i.second_period_match) begin
            high_q[u] <= low_q[u];
            lat_q[u]  <= ctrl_q[u][CTRL_DUTY_LSB +: LSB_W];
          end
        end else if (wr_high[u]) begin
          high_q[u] <= wbyte;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '0;
    end else if (ce_i) begin
      for (int u = 0; u < UNITS; u++) begin
        if (wr_ctrl[u]) begin
          pin_q[u] <= (wbyte[MODE_W-1:0] == MODE_SET_LOW);
          if (wbyte[MODE_W-1:0] == MODE_TOGGLE ||
              wbyte[MODE_W-1:0] == MODE_SOFT_IRQ ||
              wbyte[MODE_W-1:0] == MODE_TRIGGER) begin
            pin_q[u] <= pin_q[u];
          end
        end else if (ctrl_q[u][MODE_W-1:0] == MODE_OFF) begin
          pin_q[u] <= 1'b0;
        end else if (hit[u]) begin
          unique case (ctrl_q[u][MODE_W-1:0])
            MODE_TOGGLE:   pin_q[u] <= !pin_q[u];
            MODE_SET_HIGH: pin_q[u] <= 1'b1;
            MODE_SET_LOW:  pin_q[u] <= 1'b0;
            default:       pin_q[u] <= pin_q[u];
          endcase
        end else if (is_pwm(ctrl_q[u][MODE_W-1:0])) begin
          if (timers_i.second_period_match) begin
            pin_q[u] <= ({low_q[u], ctrl_q[u][CTRL_DUTY_LSB +: LSB_W]}
                         != '0);
          end else if ({high_q[u], lat_q[u]} ==
                       {timers_i.second_count, timers_i.second_fine}) begin
            pin_q[u] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else if (ce_i) begin
      for (int u = 0; u < UNITS; u++) begin
        // A match in the clearing cycle is kept
        if (hit[u]) begin
          flag_q[u] <= 1'b1;
        end else if (wr_en && wb_adr_i == OFS_FLAGS && wbyte[u]) begin
          flag_q[u] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= '0;
      tbase_q  <= '0;
    end else if (ce_i) begin
      if (wr_en && wb_adr_i == OFS_ENABLE) begin
        enable_q <= wbyte[UNITS-1:0];
      end
      if (wr_en && wb_adr_i == OFS_TBASE) begin
        tbase_q <= wbyte[UNITS-1:0];
      end
    end
  end

  assign match_request_o = flag_q & enable_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_clr_q <= 1'b0;
      third_clr_q <= 1'b0;
      conv_q      <= 1'b0;
    end else if (ce_i) begin
      first_clr_q <= (fire[0] && !tbase_q[0]) || (fire[1] && !tbase_q[1]);
      third_clr_q <= (fire[0] && tbase_q[0]) || (fire[1] && tbase_q[1]);
      conv_q      <= fire[1] && adc_enable_i;
    end
  end

  assign triggers_o.first_clear = first_clr_q && !timers_i.first_write;
  assign triggers_o.third_clear = third_clr_q && !timers_i.third_write;
  assign triggers_o.conv_start  = conv_q;

  assign unit_pin_o    = pin_q;
  assign unit_pin_oe_o = ~port_c_direction_i;

endmodule

// >>> dv/pin_load_model.sv
// Load on the two compare pins, with a pull-down on each line.
// Assumes pin level and enable come straight from the unit's ports.
`timescale 1ns/100ps
module pin_load_model (
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] oe_i,
  output logic      [1:0] level_o
);
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      level_o[k] = oe_i[k] ? pin_i[k] : 1'b0;
    end
  end
endmodule

// >>> dv/dual_compare_match_unit_assertions.sv
// Port checker for the dual compare unit.
// Assumes one clock domain; bound onto the design below.
`timescale 1ns/100ps
module dual_compare_match_unit_assertions
  import compare_unit_pkg::*;
(
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic                          ce_i,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_ack_o,
  input wire compare_unit_pkg::timer_in_s   timers_i,
  input wire logic                          adc_enable_i,
  input wire logic [compare_unit_pkg::UNITS-1:0] port_c_direction_i,
  input wire logic [compare_unit_pkg::UNITS-1:0] unit_pin_o,
  input wire logic [compare_unit_pkg::UNITS-1:0] unit_pin_oe_o,
  input wire logic [compare_unit_pkg::UNITS-1:0] match_request_o,
  input wire compare_unit_pkg::trigger_s    triggers_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing");
  a_ack_one_pulse: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  a_oe_from_dir: assert property (
    unit_pin_oe_o == ~port_c_direction_i)
    else $error("enable wrong");
  a_first_clear_pulse: assert property (
    triggers_o.first_clear |=> !triggers_o.first_clear)
    else $error("clear not a pulse");
  a_write_beats_first: assert property (
    timers_i.first_write |-> !triggers_o.first_clear)
    else $error("clear beat write");
  a_write_beats_third: assert property (
    timers_i.third_write |-> !triggers_o.third_clear)
    else $error("clear beat write");
  a_conv_needs_adc: assert property (
    triggers_o.conv_start |-> $past(adc_enable_i))
    else $error("conversion while off");
  a_third_clear_pulse: assert property (
    triggers_o.third_clear |=> !triggers_o.third_clear)
    else $error("third clear not a pulse");
  a_conv_one_pulse: assert property (
    triggers_o.conv_start |=> !triggers_o.conv_start)
    else $error("conversion start not a pulse");
  a_reset_clears: assert property (
    $fell(rst_i) |-> unit_pin_o == 2'h0 && match_request_o == 2'h0)
    else $error("reset left state");
endmodule

bind dual_compare_match_unit dual_compare_match_unit_assertions chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .timers_i(timers_i),
  .adc_enable_i(adc_enable_i), .port_c_direction_i(port_c_direction_i),
  .unit_pin_o(unit_pin_o), .unit_pin_oe_o(unit_pin_oe_o),
  .match_request_o(match_request_o), .triggers_o(triggers_o));

// >>> dv/dual_compare_match_unit_tb_top.sv
// Testbench for the dual compare unit: bus tasks and match scenarios.
// Assumes the checker is bound in its own file; ce_i is held high.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  err_total++; $display("BAD t=%0t got %0h exp %0h", $time, a, b); \
  end end
module dual_compare_match_unit_tb_top;
  import compare_unit_pkg::*;
  logic              clk_i, rst_i, cyc, stb, we, adc, ack;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wdat, rdat, dat_o;
  logic [1:0]        dir, level, pin, oe, req;
  timer_in_s         tmr;
  trigger_s          trg;
  int                err_total, num_checks, n_fc, n_tc, n_cv, u, i;
  // Toggle, high, low, soft, trigger; expected pin before and after
  logic [3:0]        md [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
  logic [4:0]        p0 = 5'b00100;
  logic [4:0]        p1 = 5'b00011;
  dual_compare_match_unit dual_compare_match_unit_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .timers_i(tmr),
    .adc_enable_i(adc), .port_c_direction_i(dir), .unit_pin_o(pin),
    .unit_pin_oe_o(oe), .match_request_o(req), .triggers_o(trg));
  pin_load_model pin_load_model_inst (
    .pin_i(pin), .oe_i(oe), .level_o(level));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_fc += int'(trg.first_clear);
    n_tc += int'(trg.third_clear);
    n_cv += int'(trg.conv_start);
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input int a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ADDR_W'(a);
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic rchk(input int a, input logic [DATA_W-1:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rdat, e)
  endtask
  task automatic pin_is(input int k, input logic e);
    repeat (2) @(posedge clk_i);
    `CHK(pin[k], e)
    `CHK(level[k], e)
  endtask
  // Counts equal the value for a few cycles, then move past it
  task automatic hit(input logic k);
    n_fc = 0;
    n_tc = 0;
    n_cv = 0;
    @(posedge clk_i);
    if (k) tmr.third_count <= 16'h1234;
    else tmr.first_count <= 16'h1234;
    repeat (4) @(posedge clk_i);
    if (k) tmr.third_count <= 16'h1235;
    else tmr.first_count <= 16'h1235;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, dir, tmr} = '0;
    rst_i = 1'b1;
    adc = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(OFS_U1_CTRL, 32'h0);
    rchk(OFS_U2_CTRL, 32'h0);
    wb(1'b1, OFS_U1_CTRL, 8'hFF);
    rchk(OFS_U1_CTRL, 32'h3F);
    // Leave pulse-width mode, else unit 1's high byte refuses writes
    wb(1'b1, OFS_U1_CTRL, 8'h00);
    wb(1'b1, OFS_U2_HIGH, 8'hA5);
    rchk(OFS_U2_HIGH, 32'hA5);
    wb(1'b1, 6'h3C, 8'h55);
    rchk(6'h3C, 32'h0);
    wb(1'b1, OFS_ENABLE, 8'h03);
    wb(1'b1, OFS_TBASE, 8'h02);
    for (u = 0; u < 2; u++) begin
      wb(1'b1, u * 12, 8'h34);
      wb(1'b1, u * 12 + 4, 8'h12);
      for (i = 0; i < 5; i++) begin
        wb(1'b1, u * 12 + 8, 8'h00);
        pin_is(u, 1'b0);
        wb(1'b1, u * 12 + 8, {4'h0, md[i]});
        pin_is(u, p0[i]);
        hit(u[0]);
        pin_is(u, p1[i]);
        `CHK(req, 2'(1 << u))
        rchk(OFS_FLAGS, 32'(1 << u));
        `CHK(n_fc + 2 * n_tc + 4 * n_cv, (i == 4) ? (u ? 6 : 1) : 0)
        wb(1'b1, OFS_FLAGS, 8'h03);
        rchk(OFS_FLAGS, 32'h0);
        `CHK(req, 2'h0)
      end
    end
    adc <= 1'b0;
    hit(1'b1);
    `CHK(n_tc + 2 * n_cv, 1)
    adc <= 1'b1;
    tmr.first_write <= 1'b1;
    tmr.third_write <= 1'b1;
    hit(1'b1);
    `CHK(n_tc + 2 * n_cv, 2)
    tmr.first_write <= 1'b0;
    tmr.third_write <= 1'b0;
    // Both units in pulse-width mode on the one period strobe
    wb(1'b1, OFS_U1_LOW, 8'h02);
    wb(1'b1, OFS_U2_LOW, 8'h01);
    wb(1'b1, OFS_U1_CTRL, 8'h0C);
    wb(1'b1, OFS_U2_CTRL, 8'h0C);
    tmr.second_period_match <= 1'b1;
    @(posedge clk_i);
    tmr.second_period_match <= 1'b0;
    pin_is(0, 1'b1);
    pin_is(1, 1'b1);
    rchk(OFS_U1_HIGH, 32'h02);
    wb(1'b1, OFS_U1_HIGH, 8'h77);
    rchk(OFS_U1_HIGH, 32'h02);
    tmr.second_count <= 8'h02;
    pin_is(0, 1'b0);
    tmr.second_count <= 8'h00;
    tmr.second_period_match <= 1'b1;
    @(posedge clk_i);
    tmr.second_period_match <= 1'b0;
    pin_is(0, 1'b1);
    wb(1'b1, OFS_U1_CTRL, 8'h00);
    pin_is(0, 1'b0);
    dir <= 2'b01;
    @(posedge clk_i);
    @(posedge clk_i);
    `CHK({oe, level[0]}, 3'b100)
    end_sim();
  end
endmodule
